// ==== rtl/pldr_pkg.sv ====
// shared constants for the macrocell register array and its register bus
package pldr_pkg;
	// ==========================================
	// geometry
	localparam int NUM_PINS = 10;
	localparam int NUM_REGS = 20;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int NATIVE_FUSES = 14504;

	// ==========================================
	// register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_TYPE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CLKSEL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_POLARITY = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_SIGNATURE = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_REGSTATE = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_PWRSTAT = 8'h18;

	// ==========================================
	// field positions
	localparam int CTRL_LEGACY_BIT = 0;
	localparam int CTRL_KEEPER_BIT = 1;
	localparam int CTRL_SECURE_BIT = 2;
	localparam int PWR_BUSY_BIT = 0;

	// ==========================================
	// reset values
	localparam logic CTRL_LEGACY_RESET = 1'b0;
	localparam logic CTRL_KEEPER_RESET = 1'b0;
	localparam logic CTRL_SECURE_RESET = 1'b0;
	localparam logic [NUM_REGS-1:0] TYPE_RESET = 20'h00000;
	localparam logic [NUM_REGS-1:0] CLKSEL_RESET = 20'h00000;
	localparam logic [NUM_PINS-1:0] POLARITY_RESET = 10'h000;
	localparam logic [DATA_W-1:0] SIGNATURE_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] SECURED_READ = 32'hFFFFFFFF;

	// ==========================================
	// timing
	localparam int CLK_NS = 4;
	localparam int PWRUP_NS = 1000;
	// longest time: round down, at least one cycle
	localparam int PWRUP_CYCLES = (PWRUP_NS / CLK_NS) < 1 ? 1 : (PWRUP_NS / CLK_NS);
	localparam int PWR_CNT_W = $clog2(PWRUP_CYCLES + 1);
endpackage

// ==== rtl/pldr_cell.sv ====
// one flip-flop of the array with its own clock, reset and data terms
`timescale 1ns/10ps
module pldr_cell
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic run,
	input wire logic t_type,
	input wire logic pin_sel,
	input wire logic pin_clk_rise,
	input wire logic sum_term,
	input wire logic reset_term,
	input wire logic clk_term,
	input wire logic preset,
	output logic q,
	output logic tick
);
	// ==========================================
	// state
	typedef struct packed
	{
		logic q;
		logic clk_prev;
	} pldr_cell_state_t;

	pldr_cell_state_t st;
	pldr_cell_state_t next_st;

	// clock source chosen per flop
	assign tick = run & (pin_sel ? pin_clk_rise : (clk_term & ~st.clk_prev));

	always_comb
	begin
		next_st = st;
		next_st.clk_prev = clk_term;
		if (reset_term)
		begin
			// whole flop cleared, nothing held back for release
			next_st.q = 1'b0;
		end
		else if (tick)
		begin
			if (preset)
			begin
				next_st.q = 1'b1;
			end
			else if (t_type)
			begin
				next_st.q = st.q ^ sum_term;
			end
			else
			begin
				next_st.q = sum_term;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			next_st_reset: st <= '0;
		end
		else if (ce)
		begin
			st <= next_st;
		end
	end

	// reset acts at once, without waiting for an edge
	assign q = st.q & ~reset_term;
endmodule

// ==== rtl/pldr_keeper.sv ====
// bus-friendly hold of the last driven level on one input pin
`timescale 1ns/10ps
module pldr_keeper
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic keep_en,
	input wire logic pin_level,
	input wire logic pin_driven,
	output logic level
);
	// ==========================================
	// state
	typedef struct packed
	{
		logic held;
	} pldr_keeper_state_t;

	pldr_keeper_state_t st;
	pldr_keeper_state_t next_st;

	always_comb
	begin
		next_st = st;
		if (pin_driven)
		begin
			next_st.held = pin_level;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
		end
		else if (ce)
		begin
			st <= next_st;
		end
	end

	// a floating pin without keeper reads low
	assign level = pin_driven ? pin_level : (keep_en & st.held);

	property p_keep_hold;
		@(posedge pclk) disable iff (!presetn)
		(ce && keep_en && pin_driven) ##1 (!pin_driven && keep_en) |-> level == $past(pin_level);
	endproperty
	a_keep_hold: assert property (p_keep_hold) else $error("keeper lost the last driven level");
endmodule

// ==== rtl/pldr_array.sv ====
// register array of a programmable logic device with apb configuration port
//
// Overview of operation
// - all registers clear at power-up, no clock
// - pin level is cleared register through polarity
// - each flop selectable D or T type
// - each flop clocked by term or pin
// - two flops per output cell, twenty
// - private sum, reset, clock term per flop
// - pins have input path apart from feedback
// - every register fed back separately
// - each pin enabled by own term
// - shared synchronous preset sets on clock
// - private asynchronous reset clears flop at once
// - reset clears whole flop, no stale value
// - legacy mode: D, term clock, no second feedback
// - legacy: signature zero, keepers off
// - native map: signature writable, keeper bit
// - secured: configuration reads back all ones
// - keeper holds last driven level
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module pldr_array
#(
	parameter int NUM_PINS = pldr_pkg::NUM_PINS,
	parameter int NUM_REGS = pldr_pkg::NUM_REGS
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pldr_pkg::ADDR_W-1:0] paddr,
	input wire logic [pldr_pkg::DATA_W-1:0] pwdata,
	output logic [pldr_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic clk_pin,
	input wire logic [NUM_REGS-1:0] sum_term,
	input wire logic [NUM_REGS-1:0] reset_term,
	input wire logic [NUM_REGS-1:0] clk_term,
	input wire logic preset_term,
	input wire logic [NUM_PINS-1:0] oe_term,
	output logic [NUM_REGS-1:0] reg_feedback,
	input wire logic [NUM_PINS-1:0] io_in,
	input wire logic [NUM_PINS-1:0] io_in_driven,
	output logic [NUM_PINS-1:0] io_out,
	output logic [NUM_PINS-1:0] io_oe,
	output logic [NUM_PINS-1:0] pin_to_array,
	output logic powerup_busy
);
	// ==========================================
	// elaboration checks
	generate
		if (NUM_REGS != 2 * NUM_PINS)
		begin : g_bad_cells
			$error("pldr_array needs exactly two flops per output cell");
		end
		if (NUM_REGS > pldr_pkg::DATA_W || NUM_PINS < 1)
		begin : g_bad_width
			$error("pldr_array register count does not fit one bus word");
		end
	endgenerate

	// ==========================================
	// state
	typedef struct packed
	{
		logic legacy;
		logic keeper;
		logic secure;
		logic [NUM_REGS-1:0] t_type;
		logic [NUM_REGS-1:0] clksel;
		logic [NUM_PINS-1:0] polarity;
		logic [pldr_pkg::DATA_W-1:0] signature;
		logic [pldr_pkg::PWR_CNT_W-1:0] pwr_cnt;
		logic pin_prev;
		logic [pldr_pkg::DATA_W-1:0] rdata;
		logic err;
	} pldr_array_state_t;

	pldr_array_state_t st;
	pldr_array_state_t next_st;

	logic [NUM_REGS-1:0] q;
	logic [NUM_REGS-1:0] tick;
	logic [NUM_REGS-1:0] type_eff;
	logic [NUM_REGS-1:0] clksel_eff;
	logic [NUM_REGS-1:0] second_mask;
	logic keeper_eff;
	logic run;
	logic pin_clk_rise;
	logic setup_phase;
	logic access_wr;
	logic [pldr_pkg::DATA_W-1:0] rd_word;
	logic rd_err;

	// ==========================================
	// effective configuration
	// legacy image: plain D flops on product-term clocks only
	assign type_eff = st.legacy ? '0 : st.t_type;
	assign clksel_eff = st.legacy ? '0 : st.clksel;
	assign keeper_eff = st.keeper & ~st.legacy;
	assign run = (st.pwr_cnt == '0);
	assign powerup_busy = ~run;
	assign pin_clk_rise = clk_pin & ~st.pin_prev;

	// odd flops are the second register of each cell
	generate
		for (genvar m = 0; m < NUM_REGS; m++)
		begin : g_mask
			assign second_mask[m] = (m % 2 == 1) ? ~st.legacy : 1'b1;
		end
	endgenerate

	// ==========================================
	// flops, one per sum term
	generate
		for (genvar i = 0; i < NUM_REGS; i++)
		begin : g_cell
			pldr_cell u_cell
			(
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.run(run),
				.t_type(type_eff[i]),
				.pin_sel(clksel_eff[i]),
				.pin_clk_rise(pin_clk_rise),
				.sum_term(sum_term[i]),
				.reset_term(reset_term[i]),
				.clk_term(clk_term[i]),
				.preset(preset_term),
				.q(q[i]),
				.tick(tick[i])
			);
		end
	endgenerate

	// each register reaches the array on its own line
	assign reg_feedback = q & second_mask;

	// ==========================================
	// pins
	generate
		for (genvar p = 0; p < NUM_PINS; p++)
		begin : g_pin
			pldr_keeper u_keeper
			(
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.keep_en(keeper_eff),
				.pin_level(io_in[p]),
				.pin_driven(io_in_driven[p]),
				.level(pin_to_array[p])
			);
			// first flop of the cell faces the pin
			assign io_out[p] = q[2 * p] ^ st.polarity[p];
		end
	endgenerate

	assign io_oe = oe_term;

	// ==========================================
	// apb decode
	assign setup_phase = psel & ~penable;
	assign access_wr = psel & penable & pwrite;
	assign pready = psel & penable;
	assign prdata = st.rdata;
	assign pslverr = st.err & psel & penable;

	always_comb
	begin
		rd_word = '0;
		rd_err = 1'b0;
		if (paddr == pldr_pkg::OFF_CTRL)
		begin
			rd_word[pldr_pkg::CTRL_LEGACY_BIT] = st.legacy;
			rd_word[pldr_pkg::CTRL_KEEPER_BIT] = keeper_eff;
			rd_word[pldr_pkg::CTRL_SECURE_BIT] = st.secure;
		end
		else if (paddr == pldr_pkg::OFF_TYPE)
		begin
			rd_word[NUM_REGS-1:0] = type_eff;
		end
		else if (paddr == pldr_pkg::OFF_CLKSEL)
		begin
			rd_word[NUM_REGS-1:0] = clksel_eff;
		end
		else if (paddr == pldr_pkg::OFF_POLARITY)
		begin
			rd_word[NUM_PINS-1:0] = st.polarity;
		end
		else if (paddr == pldr_pkg::OFF_SIGNATURE)
		begin
			rd_word = st.signature;
		end
		else if (paddr == pldr_pkg::OFF_REGSTATE)
		begin
			rd_word[NUM_REGS-1:0] = q;
		end
		else if (paddr == pldr_pkg::OFF_PWRSTAT)
		begin
			rd_word[pldr_pkg::PWR_BUSY_BIT] = powerup_busy;
		end
		else
		begin
			rd_err = 1'b1;
		end
		// copy protection hides every configuration word
		if (st.secure && paddr <= pldr_pkg::OFF_SIGNATURE && !rd_err)
		begin
			rd_word = pldr_pkg::SECURED_READ;
		end
	end

	// ==========================================
	// next state
	always_comb
	begin
		next_st = st;
		next_st.pin_prev = clk_pin;
		if (!run)
		begin
			// clocks ignored until the reset interval ends
			next_st.pwr_cnt = st.pwr_cnt - 1'b1;
		end
		if (setup_phase)
		begin
			next_st.rdata = pwrite ? '0 : rd_word;
			next_st.err = rd_err & ~pwrite;
			if (pwrite)
			begin
				next_st.err = ~(paddr <= pldr_pkg::OFF_SIGNATURE);
			end
		end
		// writes are frozen once secured, so the fuse goes last
		if (access_wr && !st.secure)
		begin
			if (paddr == pldr_pkg::OFF_CTRL)
			begin
				next_st.legacy = pwdata[pldr_pkg::CTRL_LEGACY_BIT];
				next_st.keeper = pwdata[pldr_pkg::CTRL_KEEPER_BIT];
				next_st.secure = pwdata[pldr_pkg::CTRL_SECURE_BIT];
			end
			else if (paddr == pldr_pkg::OFF_TYPE)
			begin
				next_st.t_type = pwdata[NUM_REGS-1:0];
			end
			else if (paddr == pldr_pkg::OFF_CLKSEL)
			begin
				next_st.clksel = pwdata[NUM_REGS-1:0];
			end
			else if (paddr == pldr_pkg::OFF_POLARITY)
			begin
				next_st.polarity = pwdata[NUM_PINS-1:0];
			end
			else if (paddr == pldr_pkg::OFF_SIGNATURE)
			begin
				next_st.signature = pwdata;
			end
		end
		if (next_st.legacy)
		begin
			// legacy image carries no signature and no keepers
			next_st.signature = '0;
			next_st.keeper = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st.legacy <= pldr_pkg::CTRL_LEGACY_RESET;
			st.keeper <= pldr_pkg::CTRL_KEEPER_RESET;
			st.secure <= pldr_pkg::CTRL_SECURE_RESET;
			st.t_type <= pldr_pkg::TYPE_RESET;
			st.clksel <= pldr_pkg::CLKSEL_RESET;
			st.polarity <= pldr_pkg::POLARITY_RESET;
			st.signature <= pldr_pkg::SIGNATURE_RESET;
			st.pwr_cnt <= pldr_pkg::PWR_CNT_W'(pldr_pkg::PWRUP_CYCLES);
			st.pin_prev <= 1'b0;
			st.rdata <= '0;
			st.err <= 1'b0;
		end
		else if (ce)
		begin
			st <= next_st;
		end
	end

	// ==========================================
	// checks
	property p_pwr_clear;
		@(posedge pclk) disable iff (!presetn)
		powerup_busy |-> (q == '0) && (tick == '0);
	endproperty
	a_pwr_clear: assert property (p_pwr_clear) else $error("register moved during power-up reset");

	property p_pin_polarity;
		@(posedge pclk) disable iff (!presetn)
		powerup_busy |-> io_out == st.polarity;
	endproperty
	a_pin_polarity: assert property (p_pin_polarity) else $error("pin level ignores buffer polarity");

	property p_async_reset;
		@(posedge pclk) disable iff (!presetn)
		(ce && reset_term != '0) |=> ((q & $past(reset_term)) == '0);
	endproperty
	a_async_reset: assert property (p_async_reset) else $error("reset term did not clear its flop");

	property p_preset;
		@(posedge pclk) disable iff (!presetn)
		(ce && preset_term && tick != '0) |=> ((q | reset_term) & $past(tick & ~reset_term)) == $past(tick & ~reset_term);
	endproperty
	a_preset: assert property (p_preset) else $error("preset did not set a clocked register");

	property p_d_load;
		@(posedge pclk) disable iff (!presetn)
		(ce && !preset_term && (tick & ~type_eff & ~reset_term) != '0) |=>
			((q ^ $past(sum_term)) & $past(tick & ~type_eff & ~reset_term) & ~reset_term) == '0;
	endproperty
	a_d_load: assert property (p_d_load) else $error("D flop did not load its sum term");

	property p_t_toggle;
		@(posedge pclk) disable iff (!presetn)
		(ce && !preset_term && (tick & type_eff & ~reset_term) != '0) |=>
			((q ^ ($past(q) ^ $past(sum_term))) & $past(tick & type_eff & ~reset_term) & ~reset_term) == '0;
	endproperty
	a_t_toggle: assert property (p_t_toggle) else $error("T flop did not toggle on its sum term");

	property p_legacy_subset;
		@(posedge pclk) disable iff (!presetn)
		st.legacy |-> (type_eff == '0) && (clksel_eff == '0) && ((reg_feedback & {NUM_PINS{2'b10}}) == '0);
	endproperty
	a_legacy_subset: assert property (p_legacy_subset) else $error("legacy mode left extended features on");

	property p_legacy_clean;
		@(posedge pclk) disable iff (!presetn)
		$rose(st.legacy) |-> (st.signature == '0) && !keeper_eff;
	endproperty
	a_legacy_clean: assert property (p_legacy_clean) else $error("legacy mode kept signature or keepers");

	property p_secure_read;
		@(posedge pclk) disable iff (!presetn)
		(ce && st.secure && setup_phase && !pwrite && paddr <= pldr_pkg::OFF_SIGNATURE) |=>
			prdata == pldr_pkg::SECURED_READ;
	endproperty
	a_secure_read: assert property (p_secure_read) else $error("secured configuration read back in clear");

	property p_oe_follow;
		@(posedge pclk) disable iff (!presetn)
		io_oe == oe_term;
	endproperty
	a_oe_follow: assert property (p_oe_follow) else $error("pin enable not driven by its own term");
endmodule

// ==== verif/pldr_board.sv ====
// board-side model driving the pin clock and the bidirectional pins
`timescale 1ns/10ps
module pldr_board
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic busy,
	input wire logic fire,
	input wire logic [9:0] drive,
	input wire logic [9:0] val,
	output logic clk_pin,
	output logic [9:0] io_in,
	output logic [9:0] io_in_driven
);
	logic [9:0] last;
	// ==========================================
	// pin clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_pin <= 1'h0;
			last <= '0;
		end
		else
		begin
			clk_pin <= fire & ~busy & ~clk_pin;
			last <= (drive & val) | (~drive & last);
		end
	end
	// ==========================================
	// pins
	// a released pin shows the inverse of its last level, so a stale value never passes
	assign io_in = (drive & val) | (~drive & ~last);
	assign io_in_driven = drive;
endmodule

// ==== verif/pldr_array_tb_top.sv ====
// self-checking bench for the macrocell register array
`timescale 1ns/10ps
module pldr_array_tb_top;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic ce = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, powerup_busy, clk_pin;
	logic fire = 1'h0;
	logic preset_term = 1'h0;
	logic [19:0] sum_term = '0;
	logic [19:0] reset_term = '0;
	logic [19:0] clk_term = '0;
	logic [19:0] reg_feedback;
	logic [9:0] oe_term = '0;
	logic [9:0] io_drive = '0;
	logic [9:0] io_val = '0;
	logic [9:0] io_in, io_in_driven, io_out, io_oe, pin_to_array;
	int error_cnt = 0;
	int n_compared = 0;

	always #2 pclk = ~pclk;

	pldr_array pldr_array_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clk_pin(clk_pin), .sum_term(sum_term), .reset_term(reset_term), .clk_term(clk_term),
		.preset_term(preset_term), .oe_term(oe_term), .reg_feedback(reg_feedback), .io_in(io_in),
		.io_in_driven(io_in_driven), .io_out(io_out), .io_oe(io_oe), .pin_to_array(pin_to_array),
		.powerup_busy(powerup_busy));
	pldr_board pldr_board_inst (.pclk(pclk), .presetn(presetn), .busy(powerup_busy), .fire(fire),
		.drive(io_drive), .val(io_val), .clk_pin(clk_pin), .io_in(io_in), .io_in_driven(io_in_driven));

	// ==========================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 16);
		if (n >= 16)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, pready, 1'h1);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, '0);
		chk(rd, exp);
	endtask

	// one rising edge on the chosen clock terms; returns once the update has landed
	task automatic tick(input logic [19:0] m);
		@(posedge pclk);
		clk_term <= m;
		@(posedge pclk);
		clk_term <= '0;
		#1;
	endtask

	task automatic pin_tick();
		@(posedge pclk);
		fire <= 1'h1;
		@(posedge pclk);
		fire <= 1'h0;
		@(posedge pclk);
		#1;
	endtask

	function automatic logic [9:0] pins(input logic [19:0] q, input logic [9:0] pol);
		for (int p = 0; p < 10; p++)
			pins[p] = q[2*p] ^ pol[p];
	endfunction

	// ==========================================
	// scenarios
	task automatic t_powerup();
		// bus works during the interval, so an inverting buffer can be tried early
		apb(1'h1, pldr_pkg::OFF_POLARITY, 32'h000003FF);
		#1;
		chk(io_out, 10'h3FF);
		apb(1'h1, pldr_pkg::OFF_POLARITY, 0);
		repeat (243) @(posedge pclk);
		#1;
		chk(powerup_busy, 1);
		chk(reg_feedback, 0);
		chk(io_out, 0);
		@(posedge pclk);
		#1;
		chk(powerup_busy, 0);
		rdchk(pldr_pkg::OFF_PWRSTAT, 0);
	endtask

	task automatic t_regs();
		rdchk(pldr_pkg::OFF_CTRL, 0);
		rdchk(pldr_pkg::OFF_TYPE, 0);
		rdchk(pldr_pkg::OFF_CLKSEL, 0);
		rdchk(pldr_pkg::OFF_POLARITY, 0);
		apb(1'h1, pldr_pkg::OFF_SIGNATURE, 32'hA5C30F96);
		rdchk(pldr_pkg::OFF_SIGNATURE, 32'hA5C30F96);
		rdchk(8'h1C, 0);
		chk(err, 1);
		apb(1'h1, pldr_pkg::OFF_REGSTATE, 32'h0000000F);
		chk(err, 1);
	endtask

	task automatic t_dtype();
		sum_term <= 20'hFFFFF;
		tick(20'h00008);
		chk(reg_feedback, 20'h00008);
		sum_term <= 20'h5A5A5;
		tick(20'hFFFFF);
		chk(reg_feedback, 20'h5A5A5);
		chk(io_out, pins(20'h5A5A5, 10'h000));
		rdchk(pldr_pkg::OFF_REGSTATE, 20'h5A5A5);
	endtask

	task automatic t_ttype();
		apb(1'h1, pldr_pkg::OFF_TYPE, 32'h0000000F);
		sum_term <= 20'h00003;
		tick(20'hFFFFF);
		chk(reg_feedback, 20'h00006);
		tick(20'hFFFFF);
		chk(reg_feedback, 20'h00005);
		sum_term <= '0;
		tick(20'hFFFFF);
		chk(reg_feedback, 20'h00005);
	endtask

	task automatic t_pinclk();
		apb(1'h1, pldr_pkg::OFF_TYPE, 0);
		apb(1'h1, pldr_pkg::OFF_CLKSEL, 32'h00000100);
		sum_term <= 20'hFFFFF;
		pin_tick();
		chk(reg_feedback, 20'h00105);
		sum_term <= '0;
		tick(20'hFFFFF);
		chk(reg_feedback, 20'h00100);
	endtask

	task automatic t_preset();
		preset_term <= 1'h1;
		tick(20'h0FFFF);
		preset_term <= 1'h0;
		chk(reg_feedback, 20'h0FFFF);
	endtask

	task automatic t_areset();
		@(posedge pclk);
		reset_term <= 20'h00010;
		#1;
		chk(reg_feedback, 20'h0FFEF);
		@(posedge pclk);
		#1;
		chk(reg_feedback, 20'h0FFEF);
		reset_term <= '0;
		@(posedge pclk);
		@(posedge pclk);
		#1;
		chk(reg_feedback, 20'h0FFEF);
	endtask

	task automatic t_pins();
		apb(1'h1, pldr_pkg::OFF_POLARITY, 32'h000003FF);
		#1;
		chk(io_out, pins(20'h0FFEF, 10'h3FF));
		oe_term <= 10'h2A5;
		#1;
		chk(io_oe, 10'h2A5);
		apb(1'h1, pldr_pkg::OFF_CTRL, 32'h00000002);
		io_drive <= 10'h3FF;
		io_val <= 10'h1B3;
		@(posedge pclk);
		#1;
		chk(pin_to_array, 10'h1B3);
		@(posedge pclk);
		io_drive <= '0;
		@(posedge pclk);
		#1;
		chk(pin_to_array, 10'h1B3);
		apb(1'h1, pldr_pkg::OFF_CTRL, 0);
		#1;
		chk(pin_to_array, 0);
	endtask

	task automatic t_legacy();
		apb(1'h1, pldr_pkg::OFF_CTRL, 32'h00000003);
		rdchk(pldr_pkg::OFF_CTRL, 1);
		chk(reg_feedback, 20'h05545);
		apb(1'h1, pldr_pkg::OFF_TYPE, 32'h000FFFFF);
		apb(1'h1, pldr_pkg::OFF_CLKSEL, 32'h000FFFFF);
		sum_term <= 20'hFFFFF;
		tick(20'hFFFFF);
		chk(reg_feedback, 20'h55555);
		apb(1'h1, pldr_pkg::OFF_SIGNATURE, 32'h12345678);
		rdchk(pldr_pkg::OFF_SIGNATURE, 0);
	endtask

	// security goes last: once set, configuration reads back all ones
	task automatic t_secure();
		apb(1'h1, pldr_pkg::OFF_CTRL, 32'h00000004);
		for (int i = 0; i < 5; i++)
			rdchk(8'(4 * i), pldr_pkg::SECURED_READ);
	endtask

	task automatic finish_test();
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================
	// main sequence and watchdog
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		t_powerup();
		t_regs();
		t_dtype();
		t_ttype();
		t_pinclk();
		t_preset();
		t_areset();
		t_pins();
		t_legacy();
		t_secure();
		finish_test();
	end

	initial
	begin
		#20000;
		error_cnt++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, n_compared, 0);
		finish_test();
	end
endmodule
